// ==== pkg/adc_mode_pkg.sv ====
// Package: shared constants and carriers for the converter mode/control block.
// Assumes a 25 MHz system clock; all pin timing is expressed in cycles of it.
package adc_mode_pkg;

    // System clock
    localparam int CLK_MHZ = 25;
    localparam int CLK_PERIOD_NS = 40;

    // Reset pulse classification (times as printed)
    localparam int PARTIAL_MIN_NS = 40;
    localparam int PARTIAL_MAX_NS = 500;
    localparam int SHUTDOWN_NS = 1200;
    localparam int PARTIAL_MIN_CYC = (PARTIAL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PARTIAL_MAX_CYC = PARTIAL_MAX_NS / CLK_PERIOD_NS;
    localparam int SHUTDOWN_CYC = (SHUTDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Host wait times after leaving shutdown (host obligation, reported as ready flags)
    localparam int WRITE_READY_US = 240;
    localparam int CONV_READY_MS = 15;
    localparam int WRITE_READY_CYC = WRITE_READY_US * CLK_MHZ;
    localparam int CONV_READY_CYC = CONV_READY_MS * 1000 * CLK_MHZ;

    // Conversion length of one oversampled sample
    localparam int CONV_CYC = 25;

    // Range code 00 is software mode
    localparam logic [1:0] RANGE_SOFTWARE = 2'h0;

    // Interface selections
    typedef enum logic [1:0] {IF_PARALLEL, IF_BYTE, IF_SERIAL} iface_type;

    // Configuration caught at release of a full reset
    typedef struct packed {
        logic hardware_mode;
        iface_type iface;
        logic check_enable;
        logic burst;
        logic sequencer_enable;
        logic [2:0] oversample_ratio;
        logic reference_select;
        logic serial_one_wire;
    } latched_cfg_type;

    localparam latched_cfg_type CFG_RESET = '{
        hardware_mode: 1'b0, iface: IF_PARALLEL, check_enable: 1'b0, burst: 1'b0,
        sequencer_enable: 1'b0, oversample_ratio: 3'h0, reference_select: 1'b0,
        serial_one_wire: 1'b0};

    // Host strobes as one group
    typedef struct packed {
        logic chip_select_n;
        logic read_strobe_n;
        logic write_strobe_n;
        logic serial_clock;
    } host_strobe_type;

endpackage : adc_mode_pkg

// ==== hw/adc_conversion_mode_control.sv ====
// Conversion control, host strobe handling and mode latching for a dual
// simultaneous-sampling converter. Assumes every pin input is asynchronous to
// clk, a result source outside this block, and a wire resolver in the bench.
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
module adc_conversion_mode_control #(
    parameter int WRITE_READY_CYC = adc_mode_pkg::WRITE_READY_CYC,
    parameter int CONV_READY_CYC = adc_mode_pkg::CONV_READY_CYC
) (
    // System
    input wire logic clk,
    input wire logic reset_n,
    // Device reset pin, asynchronous, classified by pulse length
    input wire logic device_reset_n,
    // Mode and configuration pins
    input wire logic [1:0] range_select,
    input wire logic interface_select,
    input wire logic byte_or_serial_select,
    input wire logic sequencer_enable,
    input wire logic check_enable,
    input wire logic burst,
    input wire logic [2:0] oversample_ratio,
    input wire logic reference_select,
    input wire logic serial_one_wire,
    input wire logic [2:0] channel_pair_select,
    // Conversion control
    input wire logic conversion_start,
    output logic busy,
    output logic [2:0] converting_pair,
    // Host strobes
    input wire adc_mode_pkg::host_strobe_type host_strobe,
    // Data bus, three signals per line
    input wire logic [15:0] parallel_data_bus_in,
    output logic [15:0] parallel_data_bus_out,
    output logic [15:0] parallel_data_bus_oe_n,
    // Result to present and register write port toward the core
    input wire logic [15:0] result_word,
    output logic reg_write,
    output logic [15:0] reg_write_data,
    output logic frame_start,
    output logic serial_sample,
    // Status
    output adc_mode_pkg::latched_cfg_type latched_cfg,
    output logic shutdown,
    output logic write_ready,
    output logic conv_ready
);

    // Two-flop synchronisers for all asynchronous inputs
    localparam int SYNC_W = 4 + 1 + 1;
    logic [SYNC_W-1:0] sync1_ff, sync2_ff, prev_ff;
    wire [SYNC_W-1:0] async_in = {host_strobe, device_reset_n, conversion_start};
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_ff <= '1;
            sync2_ff <= '1;
            prev_ff <= '1;
        end else begin
            sync1_ff <= async_in;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end
    logic [2:0] pair_s1_ff, pair_s2_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pair_s1_ff <= 3'h0;
            pair_s2_ff <= 3'h0;
        end else begin
            pair_s1_ff <= channel_pair_select;
            pair_s2_ff <= pair_s1_ff;
        end
    end
    // Mode pins and data lines pass two flops as well; both are read
    // long after they settle, so the added latency costs nothing
    localparam int PIN_W = 12 + 16;
    logic [PIN_W-1:0] pin_s1_ff, pin_s2_ff;
    wire [PIN_W-1:0] pin_in = {range_select, interface_select, byte_or_serial_select, sequencer_enable,
        check_enable, burst, oversample_ratio, reference_select, serial_one_wire, parallel_data_bus_in};
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
        end else begin
            pin_s1_ff <= pin_in;
            pin_s2_ff <= pin_s1_ff;
        end
    end
    wire [1:0] range_s = pin_s2_ff[27:26];
    wire ifsel_s = pin_s2_ff[25];
    wire bos_s = pin_s2_ff[24];
    wire seq_s = pin_s2_ff[23];
    wire check_s = pin_s2_ff[22];
    wire burst_s = pin_s2_ff[21];
    wire [2:0] os_s = pin_s2_ff[20:18];
    wire ref_s = pin_s2_ff[17];
    wire one_wire_s = pin_s2_ff[16];
    wire [15:0] bus_in_s = pin_s2_ff[15:0];

    // Named synchronised levels and edges
    wire start_s = sync2_ff[0];
    wire start_rise = sync2_ff[0] & ~prev_ff[0];
    wire rst_pin_s = sync2_ff[1];
    wire rst_rise = sync2_ff[1] & ~prev_ff[1];
    wire sclk_s = sync2_ff[2];
    wire sclk_rise = sync2_ff[2] & ~prev_ff[2];
    wire wr_n_s = sync2_ff[3];
    wire rd_n_s = sync2_ff[4];
    wire cs_n_s = sync2_ff[5];
    wire cs_fall = ~sync2_ff[5] & prev_ff[5];
    wire cs_rise = sync2_ff[5] & ~prev_ff[5];
    wire wr_rise = sync2_ff[3] & ~prev_ff[3];

    // Reset pulse width counter; saturates at the shutdown threshold
    logic [5:0] low_cnt_ff;
    wire [5:0] nxt_low_cnt = rst_pin_s ? 6'h00 :
        (low_cnt_ff == 6'(adc_mode_pkg::SHUTDOWN_CYC)) ? low_cnt_ff : low_cnt_ff + 6'h01;
    // Gated by the pin level: the count still stands on the release edge,
    // and an ungated flag there would hold shutdown and block the reload
    wire long_low = !rst_pin_s && (low_cnt_ff >= 6'(adc_mode_pkg::SHUTDOWN_CYC));
    wire full_release = rst_rise & (low_cnt_ff > 6'(adc_mode_pkg::PARTIAL_MAX_CYC));
    wire partial_release = rst_rise & (low_cnt_ff >= 6'(adc_mode_pkg::PARTIAL_MIN_CYC))
        & (low_cnt_ff <= 6'(adc_mode_pkg::PARTIAL_MAX_CYC));
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) low_cnt_ff <= 6'h00;
        else low_cnt_ff <= nxt_low_cnt;
    end

    // Shutdown flag: entered on a long low, left on the release edge
    logic shutdown_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) shutdown_ff <= 1'b1;
        else if (long_low) shutdown_ff <= 1'b1;
        else if (rst_rise) shutdown_ff <= 1'b0;
    end
    assign shutdown = shutdown_ff;

    // Mode decode from pins at release of a full reset
    wire hw_pins = range_s != adc_mode_pkg::RANGE_SOFTWARE;
    wire adc_mode_pkg::iface_type iface_pins = !ifsel_s ? adc_mode_pkg::IF_PARALLEL :
        bos_s ? adc_mode_pkg::IF_BYTE : adc_mode_pkg::IF_SERIAL;
    adc_mode_pkg::latched_cfg_type cfg_ff, nxt_cfg;
    always_comb begin
        nxt_cfg = adc_mode_pkg::CFG_RESET;
        nxt_cfg.hardware_mode = hw_pins;
        nxt_cfg.iface = iface_pins;
        nxt_cfg.reference_select = ref_s;
        nxt_cfg.serial_one_wire = one_wire_s;
        if (hw_pins) begin
            nxt_cfg.check_enable = check_s;
            nxt_cfg.burst = burst_s;
            nxt_cfg.sequencer_enable = seq_s;
            nxt_cfg.oversample_ratio = os_s;
        end
    end
    // Only a full release reloads; partial reset keeps the latched set
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) cfg_ff <= adc_mode_pkg::CFG_RESET;
        else if (long_low) cfg_ff <= adc_mode_pkg::CFG_RESET;
        else if (full_release) cfg_ff <= nxt_cfg;
    end
    assign latched_cfg = cfg_ff;

    // Power-up wait counters after leaving shutdown
    logic [31:0] up_cnt_ff;
    logic write_ready_ff, conv_ready_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            up_cnt_ff <= 32'h0000_0000;
            write_ready_ff <= 1'b0;
            conv_ready_ff <= 1'b0;
        end else if (shutdown_ff || !rst_pin_s) begin
            up_cnt_ff <= 32'h0000_0000;
            write_ready_ff <= write_ready_ff & ~shutdown_ff;
            conv_ready_ff <= conv_ready_ff & ~shutdown_ff;
        end else begin
            if (!conv_ready_ff) up_cnt_ff <= up_cnt_ff + 32'h0000_0001;
            write_ready_ff <= write_ready_ff | (up_cnt_ff >= 32'(WRITE_READY_CYC));
            conv_ready_ff <= conv_ready_ff | (up_cnt_ff >= 32'(CONV_READY_CYC));
        end
    end
    assign write_ready = write_ready_ff;
    assign conv_ready = conv_ready_ff;

    // Conversion sequencer; each step is one oversampled pair of samples
    typedef enum logic [1:0] {CONV_IDLE, CONV_RUN, CONV_LATCH} conv_state_type;
    conv_state_type state_ff, nxt_state;
    logic [15:0] conv_cnt_ff;
    logic [2:0] pair_ff, last_pair_ff;
    wire seq_hw = cfg_ff.hardware_mode & cfg_ff.sequencer_enable;
    wire burst_hw = seq_hw & cfg_ff.burst;
    wire halt = !rst_pin_s || shutdown_ff; // Pin low aborts conversion
    wire [15:0] conv_len = 16'(adc_mode_pkg::CONV_CYC) << cfg_ff.oversample_ratio;
    wire conv_done = conv_cnt_ff == conv_len - 16'h0001;
    wire more_pairs = burst_hw && (pair_ff != last_pair_ff);
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            CONV_IDLE: if (start_rise && !halt) nxt_state = CONV_RUN;
            CONV_RUN: if (conv_done) nxt_state = CONV_LATCH;
            CONV_LATCH: nxt_state = more_pairs ? CONV_RUN : CONV_IDLE;
            default: nxt_state = CONV_IDLE;
        endcase
        if (halt) nxt_state = CONV_IDLE;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= CONV_IDLE;
            conv_cnt_ff <= 16'h0000;
            pair_ff <= 3'h0;
            last_pair_ff <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            conv_cnt_ff <= (state_ff == CONV_RUN && !conv_done) ? conv_cnt_ff + 16'h0001 : 16'h0000;
            if (state_ff == CONV_IDLE && start_rise) begin
                pair_ff <= seq_hw ? 3'h0 : pair_s2_ff;
                last_pair_ff <= pair_s2_ff;
            end else if (state_ff == CONV_LATCH && more_pairs) begin
                pair_ff <= pair_ff + 3'h1;
            end
        end
    end

    // Busy registered: high from start edge until results are latched
    logic busy_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) busy_ff <= 1'b0;
        else busy_ff <= (nxt_state != CONV_IDLE);
    end
    assign busy = busy_ff;
    assign converting_pair = pair_ff;

    // Output holding register, loaded when a conversion is latched
    logic [15:0] hold_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) hold_ff <= 16'h0000;
        else if (state_ff == CONV_LATCH) hold_ff <= result_word;
    end

    // Data bus drive; low enable drives the line
    wire read_on = !cs_n_s && !rd_n_s && (cfg_ff.iface != adc_mode_pkg::IF_SERIAL);
    wire [15:0] lane_mask = (cfg_ff.iface == adc_mode_pkg::IF_BYTE) ? 16'h00FF : 16'hFFFF;
    logic [15:0] bus_out_ff, bus_oe_n_ff;
    logic [3:0] bit_cnt_ff;
    logic [15:0] shift_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_out_ff <= 16'h0000;
            bus_oe_n_ff <= 16'hFFFF;
        end else if (cs_rise || cs_n_s) begin
            bus_oe_n_ff <= 16'hFFFF;
        end else if (cfg_ff.iface == adc_mode_pkg::IF_SERIAL) begin
            bus_out_ff <= {3'h0, shift_ff[15], 12'h000};
            bus_oe_n_ff <= 16'hEFFF; // Serial data A on line 12, mode 0
        end else begin
            bus_out_ff <= hold_ff & lane_mask;
            bus_oe_n_ff <= read_on ? ~lane_mask : 16'hFFFF;
        end
    end
    assign parallel_data_bus_out = bus_out_ff;
    assign parallel_data_bus_oe_n = bus_oe_n_ff;

    // Serial shift: load at frame start, shift on each rising clock edge
    logic frame_ff, sample_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_ff <= 16'h0000;
            bit_cnt_ff <= 4'h0;
            frame_ff <= 1'b0;
            sample_ff <= 1'b0;
        end else begin
            frame_ff <= cs_fall;
            sample_ff <= 1'b0;
            if (cs_fall) begin
                shift_ff <= hold_ff;
                bit_cnt_ff <= 4'h0;
            end else if (!cs_n_s && sclk_rise && cfg_ff.iface == adc_mode_pkg::IF_SERIAL) begin
                shift_ff <= {shift_ff[14:0], 1'b0};
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
                sample_ff <= 1'b1;
            end
        end
    end
    assign frame_start = frame_ff;
    assign serial_sample = sample_ff;

    // Register write: only software mode, parallel or byte, on strobe release
    logic reg_write_ff;
    logic [15:0] wdata_ff;
    wire write_ok = !cfg_ff.hardware_mode && !cs_n_s && wr_rise
        && (cfg_ff.iface != adc_mode_pkg::IF_SERIAL) && !shutdown_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_write_ff <= 1'b0;
            wdata_ff <= 16'h0000;
        end else begin
            reg_write_ff <= write_ok;
            if (write_ok) wdata_ff <= bus_in_s & lane_mask;
        end
    end
    assign reg_write = reg_write_ff;
    assign reg_write_data = wdata_ff;

    // Busy must not rise without a start edge from idle
    chk_busy_needs_start: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(busy) |-> $past(start_rise) || $past(state_ff) == CONV_LATCH)
        else $error("busy rose without start");
    chk_busy_holds_run: assert property (@(posedge clk) disable iff (!reset_n)
        busy && state_ff == CONV_RUN && start_rise && !halt |=> busy)
        else $error("start disturbed busy");
    chk_busy_falls_latch: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(busy) |-> $past(state_ff) == CONV_LATCH || $past(halt))
        else $error("busy fell before latch");
    chk_byte_lanes: assert property (@(posedge clk) disable iff (!reset_n)
        cfg_ff.iface == adc_mode_pkg::IF_BYTE |-> parallel_data_bus_oe_n[15:8] == 8'hFF)
        else $error("byte mode drove upper lines");
    chk_cs_release: assert property (@(posedge clk) disable iff (!reset_n)
        cs_rise |=> parallel_data_bus_oe_n == 16'hFFFF)
        else $error("bus driven after chip select rose");
    chk_par_read: assert property (@(posedge clk) disable iff (!reset_n)
        read_on && cfg_ff.iface == adc_mode_pkg::IF_PARALLEL && !cs_rise |=> parallel_data_bus_oe_n == 16'h0000)
        else $error("parallel read not driven");
    chk_hw_no_write: assert property (@(posedge clk) disable iff (!reset_n)
        cfg_ff.hardware_mode |-> !reg_write)
        else $error("register write in hardware mode");
    chk_shutdown_entry: assert property (@(posedge clk) disable iff (!reset_n)
        long_low |=> shutdown && latched_cfg == adc_mode_pkg::CFG_RESET)
        else $error("long reset did not shut down");
    chk_partial_keeps: assert property (@(posedge clk) disable iff (!reset_n)
        partial_release |=> $stable(cfg_ff))
        else $error("partial reset changed configuration");
    chk_frame_pulse: assert property (@(posedge clk) disable iff (!reset_n)
        cs_fall |=> frame_start)
        else $error("frame start missing");
    // Release edge, sample pulses, loaded set and serial lane
    chk_shutdown_exit: assert property (@(posedge clk) disable iff (!reset_n)
        rst_rise |=> !shutdown)
        else $error("shutdown kept after release");
    chk_full_loads: assert property (@(posedge clk) disable iff (!reset_n)
        full_release |=> latched_cfg == $past(nxt_cfg))
        else $error("full release did not load pins");
    chk_sample_rise: assert property (@(posedge clk) disable iff (!reset_n)
        serial_sample |-> $past(sclk_rise))
        else $error("serial sample without clock rise");
    chk_serial_lane: assert property (@(posedge clk) disable iff (!reset_n)
        cfg_ff.iface == adc_mode_pkg::IF_SERIAL && !cs_n_s |=> parallel_data_bus_oe_n == 16'hEFFF)
        else $error("serial frame not on line 12");

endmodule : adc_conversion_mode_control

// ==== verification/adc_host_model.sv ====
// Host model: chip select, strobes, serial clock and its side of the data lines.
// Assumes the bench calls its tasks just after a clock edge of the device clock.
`timescale 1ns/10ps
module adc_host_model (
    // Clock
    input wire logic clk,
    // Device side of the data lines
    input wire logic [15:0] bus_out,
    input wire logic [15:0] bus_oe_n,
    output logic [15:0] bus_in,
    // Strobes
    output adc_mode_pkg::host_strobe_type strobe
);
    logic [15:0] host_data = 16'h0000;
    logic host_drive = 1'b0;

    initial strobe = 4'he;
    // Released lines show the inverse, so a stale value never passes as read data
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            bus_in[i] = !bus_oe_n[i] ? bus_out[i] : (host_drive ? host_data[i] : ~bus_out[i]);
        end
    end

    // Sample after the edge has settled
    task automatic wait_cyc(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask : wait_cyc

    // Read: select and read strobe low together, held past the sync delay
    task automatic do_read(output logic [15:0] data, output logic [15:0] oe_n);
        strobe.chip_select_n <= 1'b0;
        strobe.read_strobe_n <= 1'b0;
        wait_cyc(6);
        data = bus_in;
        oe_n = bus_oe_n;
        strobe.chip_select_n <= 1'b1;
        strobe.read_strobe_n <= 1'b1;
        wait_cyc(1);
    endtask : do_read

    // Write: data held from the fall of the strobes until select rises
    task automatic do_write(input logic [15:0] data);
        host_data <= data;
        host_drive <= 1'b1;
        strobe.chip_select_n <= 1'b0;
        strobe.write_strobe_n <= 1'b0;
        wait_cyc(5);
        strobe.write_strobe_n <= 1'b1;
        wait_cyc(5);
        strobe.chip_select_n <= 1'b1;
        host_drive <= 1'b0;
        wait_cyc(1);
    endtask : do_write

    // Mode 0 frame at 320 ns: clock idles low, line 12 taken at each rise
    task automatic do_serial(output logic [15:0] data);
        strobe.chip_select_n <= 1'b0;
        wait_cyc(4);
        for (int i = 15; i >= 0; i--) begin
            strobe.serial_clock <= 1'b1;
            data[i] = bus_in[12];
            wait_cyc(4);
            strobe.serial_clock <= 1'b0;
            wait_cyc(4);
        end
        strobe.chip_select_n <= 1'b1;
        wait_cyc(1);
    endtask : do_serial
endmodule : adc_host_model

// ==== verification/testbench.sv ====
// Bench: mode latching, conversions and host reads of the control block.
// Assumes the host model holds the strobe pins and the bench drives the rest.
`timescale 1ns/10ps
`define CHK(what, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("MISMATCH %s expected %h seen %h", what, exp, got); \
        end \
    end
module testbench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic device_reset_n = 1'b0;
    logic [1:0] range_select = 2'h1;
    logic interface_select = 1'b0;
    logic byte_or_serial_select = 1'b0;
    logic sequencer_enable = 1'b0;
    logic check_enable = 1'b0;
    logic burst = 1'b0;
    logic [2:0] oversample_ratio = 3'h0;
    logic reference_select = 1'b0;
    logic serial_one_wire = 1'b0;
    logic [2:0] channel_pair_select = 3'h0;
    logic conversion_start = 1'b0;
    logic [15:0] result_word = 16'h0000;
    logic busy, reg_write, frame_start, serial_sample, shutdown, write_ready, conv_ready;
    logic [2:0] converting_pair;
    logic [15:0] bus_in, bus_out, bus_oe_n, reg_write_data, rd_data, rd_oe;
    logic [15:0] wr_data = 16'h0000;
    logic [2:0] flags;
    adc_mode_pkg::host_strobe_type host_strobe;
    adc_mode_pkg::latched_cfg_type latched_cfg, saved_cfg;
    int num_errors = 0;
    int tests_run = 0;
    int wr_cnt = 0;
    int frame_cnt = 0;
    int samp_cnt = 0;

    assign flags = {conv_ready, shutdown, busy};
    // 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end
    // Tally pulses so scenarios compare counts, not single moments
    always @(posedge clk) begin
        if (reg_write === 1'b1) begin
            wr_cnt++;
            wr_data = reg_write_data;
        end
        if (frame_start === 1'b1) begin
            frame_cnt++;
        end
        if (serial_sample === 1'b1) begin
            samp_cnt++;
        end
    end

    adc_conversion_mode_control #(.WRITE_READY_CYC(50), .CONV_READY_CYC(100)) i_adc_conversion_mode_control (
        .clk(clk), .reset_n(reset_n), .device_reset_n(device_reset_n), .range_select(range_select),
        .interface_select(interface_select), .byte_or_serial_select(byte_or_serial_select),
        .sequencer_enable(sequencer_enable), .check_enable(check_enable), .burst(burst),
        .oversample_ratio(oversample_ratio), .reference_select(reference_select),
        .serial_one_wire(serial_one_wire), .channel_pair_select(channel_pair_select),
        .conversion_start(conversion_start), .busy(busy), .converting_pair(converting_pair),
        .host_strobe(host_strobe), .parallel_data_bus_in(bus_in), .parallel_data_bus_out(bus_out),
        .parallel_data_bus_oe_n(bus_oe_n), .result_word(result_word), .reg_write(reg_write),
        .reg_write_data(reg_write_data), .frame_start(frame_start), .serial_sample(serial_sample),
        .latched_cfg(latched_cfg), .shutdown(shutdown), .write_ready(write_ready), .conv_ready(conv_ready));

    adc_host_model host (.clk(clk), .bus_out(bus_out), .bus_oe_n(bus_oe_n), .bus_in(bus_in), .strobe(host_strobe));

    task automatic close_out();
        if (num_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    // One cycle, leaving the edge's updates time to land
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic wait_flag(input int idx, input logic lvl, input int lim);
        for (int i = 0; i < lim; i++) begin
            tick();
            if (flags[idx] === lvl) return;
        end
        $display("MISMATCH flag %0d expected %h seen %h", idx, lvl, flags[idx]);
        num_errors++;
        close_out();
    endtask : wait_flag

    task automatic set_pins(input logic [1:0] rng, input logic ifs, bos, seq, bst, input logic [2:0] os, input logic ext);
        range_select <= rng;
        interface_select <= ifs;
        byte_or_serial_select <= bos;
        sequencer_enable <= seq;
        burst <= bst;
        oversample_ratio <= os;
        check_enable <= ext;
        reference_select <= ext;
        serial_one_wire <= ext;
    endtask : set_pins

    // Host waits for shutdown to clear and for conv_ready before going on
    task automatic full_reset();
        device_reset_n <= 1'b0;
        repeat (20) tick();
        device_reset_n <= 1'b1;
        // Configuration lands three edges after the pin rises
        repeat (4) tick();
        wait_flag(1, 1'b0, 10);
        wait_flag(2, 1'b1, 200);
    endtask : full_reset

    // Start, pulse start again mid-conversion, count busy cycles
    task automatic convert(input logic [2:0] pair, input logic [2:0] exp_pair, input int exp_cyc);
        int n;
        channel_pair_select <= pair;
        conversion_start <= 1'b1;
        wait_flag(0, 1'b1, 10);
        `CHK("first pair", exp_pair, converting_pair)
        n = 0;
        while (busy === 1'b1 && n < 3000) begin
            n++;
            if (n == 4) conversion_start <= 1'b0;
            if (n == 8) conversion_start <= 1'b1;
            if (n == 12) conversion_start <= 1'b0;
            tick();
        end
        `CHK("busy cycles", exp_cyc, n)
        repeat (12) tick();
        `CHK("busy after stray start", 1'b0, busy)
    endtask : convert

    task automatic read_check(input logic [15:0] exp, exp_oe, mask);
        int f;
        f = frame_cnt;
        `CHK("busy before read", 1'b0, busy)
        host.do_read(rd_data, rd_oe);
        `CHK("read data", exp & mask, rd_data & mask)
        `CHK("read enables", exp_oe, rd_oe)
        repeat (4) tick();
        `CHK("released enables", 16'hFFFF, bus_oe_n)
        `CHK("frames", f + 1, frame_cnt)
    endtask : read_check

    task automatic hw_parallel();
        int w;
        result_word <= 16'hA5C3;
        convert(3'h5, 3'h5, 26);
        read_check(16'hA5C3, 16'h0000, 16'hFFFF);
        w = wr_cnt;
        host.do_write(16'h1234);
        `CHK("write in hardware mode", w, wr_cnt)
    endtask : hw_parallel

    task automatic hw_burst();
        saved_cfg = latched_cfg;
        set_pins(2'h2, 1'b0, 1'b0, 1'b1, 1'b1, 3'h1, 1'b1);
        device_reset_n <= 1'b0;
        repeat (5) tick();
        device_reset_n <= 1'b1;
        repeat (6) tick();
        `CHK("config after partial reset", saved_cfg, latched_cfg)
        full_reset();
        `CHK("hw pins", 6'h39, {latched_cfg.check_enable, latched_cfg.burst, latched_cfg.sequencer_enable,
            latched_cfg.oversample_ratio})
        convert(3'h2, 3'h0, 153);
    endtask : hw_burst

    task automatic hw_byte();
        set_pins(2'h3, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0);
        full_reset();
        `CHK("byte interface", adc_mode_pkg::IF_BYTE, latched_cfg.iface)
        result_word <= 16'h5A3C;
        convert(3'h3, 3'h3, 26);
        read_check(16'h5A3C, 16'hFF00, 16'h00FF);
    endtask : hw_byte

    task automatic hw_serial();
        int f, s;
        set_pins(2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 1'b1);
        full_reset();
        `CHK("serial interface", adc_mode_pkg::IF_SERIAL, latched_cfg.iface)
        result_word <= 16'hC35A;
        convert(3'h6, 3'h6, 26);
        f = frame_cnt;
        s = samp_cnt;
        host.do_serial(rd_data);
        `CHK("serial data", 16'hC35A, rd_data)
        `CHK("serial frames", f + 1, frame_cnt)
        `CHK("serial samples", s + 16, samp_cnt)
    endtask : hw_serial

    task automatic sw_parallel();
        int w;
        set_pins(2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 1'b1);
        full_reset();
        `CHK("sw mode bits", 3'h1, {latched_cfg.hardware_mode, latched_cfg.burst,
            latched_cfg.reference_select})
        w = wr_cnt;
        host.do_write(16'h2468);
        `CHK("writes", w + 1, wr_cnt)
        `CHK("write data", 16'h2468, wr_data)
        device_reset_n <= 1'b0;
        repeat (35) tick();
        `CHK("shutdown", 1'b1, shutdown)
        `CHK("cleared config", adc_mode_pkg::CFG_RESET, latched_cfg)
        device_reset_n <= 1'b1;
    endtask : sw_parallel

    initial begin
        repeat (4) tick();
        reset_n <= 1'b1;
        tick();
        `CHK("shutdown at start", 1'b1, shutdown)
        repeat (40) tick();
        device_reset_n <= 1'b1;
        wait_flag(1, 1'b0, 10);
        `CHK("write ready early", 1'b0, write_ready)
        wait_flag(2, 1'b1, 200);
        `CHK("hardware mode", 1'b1, latched_cfg.hardware_mode)
        hw_parallel();
        hw_burst();
        hw_byte();
        hw_serial();
        sw_parallel();
        close_out();
    end
endmodule : testbench
